// ==== hdl/hdlc_rx_status.sv ====
`timescale 1ns/10ps
// What this block does
// - Mask bits 7..3 enable receive-side events
// - Mask bits 2..0 transmit events, one enables
// - Seven or more ones sets abort flag
// - Checksum mismatch sets CRC error flag
// - Write into full FIFO sets overrun
// - Checked complete packet sets valid flag
// - Bit 2 marks last byte, good packet
// - Bit 1 marks last byte of packet
// - Bit 0 marks first byte of packet
// - Receive flags sticky, cleared by reading
// - Status latched events clear on read
// - Half full past midpoint, not empty
module hdlc_rx_status #(
  parameter int FIFO_DEPTH = hdlc_stat_pkg::RX_FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [7:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  input wire logic crc_bad,
  input wire logic packet_checked_ok,
  input wire logic fifo_push,
  input wire logic [$clog2(hdlc_stat_pkg::RX_FIFO_DEPTH):0] fifo_level,
  input wire logic head_first,
  input wire logic head_last,
  input wire logic head_good,
  input wire logic code_detector_change,
  input wire logic packet_start_event,
  input wire logic packet_end_event,
  input wire logic tx_fifo_half_empty,
  input wire logic tx_fifo_has_room,
  input wire logic tx_message_done,
  output logic irq_n
);
  import hdlc_stat_pkg::*;
  initial begin
    if (FIFO_DEPTH != RX_FIFO_DEPTH) $error("FIFO_DEPTH must match level port width");
  end
  localparam int LW = $clog2(RX_FIFO_DEPTH) + 1;
  localparam logic [LW-1:0] HALF_LEVEL = LW'(FIFO_DEPTH / 2);

  logic [7:0] hdlc_irq_enable_q;
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic [3:0] sticky_q;
  logic [3:0] sticky_d;
  logic abort_pulse;
  logic [7:0] live_events;
  logic [7:0] event_view;
  logic [7:0] rx_info_view;
  logic [3:0] rx_sets;
  logic sel_status;
  logic sel_enable;
  logic sel_info;
  logic rd_status;
  logic rd_info;
  logic [7:0] rd_mux;
  logic rx_fifo_half_full;
  logic rx_fifo_has_data;
  logic rx_fifo_is_empty;
  logic overrun_d;

  hdlc_ones_run #(.RUN(ABORT_ONES)) u_run (
    .clock(clock),
    .resetn(resetn),
    .enable(clk_en),
    .bit_valid(rx_bit_valid),
    .bit_value(rx_bit),
    .abort_pulse(abort_pulse)
  );

  // Address decoding
  assign sel_status = (addr == ADDR_EVENT_STATUS);
  assign sel_enable = (addr == ADDR_IRQ_ENABLE);
  assign sel_info = (addr == ADDR_RX_INFO);
  assign rd_status = rd_en && sel_status;
  assign rd_info = rd_en && sel_info;

  // Live FIFO levels
  assign rx_fifo_half_full = fifo_level > HALF_LEVEL;
  assign rx_fifo_has_data = fifo_level != '0;
  assign rx_fifo_is_empty = fifo_level == '0;
  assign overrun_d = fifo_push && (fifo_level >= LW'(FIFO_DEPTH));

  // Event inputs; level ones pass straight, pulse ones get latched
  assign live_events = {code_detector_change, packet_end_event, packet_start_event,
                        rx_fifo_half_full, rx_fifo_has_data, tx_fifo_half_empty,
                        tx_fifo_has_room, tx_message_done};
  // Set beats the read clear so no event is lost
  assign status_d = (LATCHED_EVENTS & live_events) |
                    ((rd_status ? 8'h00 : status_q) & LATCHED_EVENTS);
  assign event_view = (LATCHED_EVENTS & status_q) | (~LATCHED_EVENTS & live_events);

  // Sticky receive flags: abort, crc, overrun, valid
  assign rx_sets = {abort_pulse, crc_bad, overrun_d, packet_checked_ok};
  assign sticky_d = rx_sets | (rd_info ? 4'h0 : sticky_q);
  // Head-of-FIFO marks are live, only meaningful while a byte waits
  assign rx_info_view = {sticky_q, rx_fifo_is_empty,
                         head_last && head_good && !rx_fifo_is_empty,
                         head_last && !rx_fifo_is_empty,
                         head_first && !rx_fifo_is_empty};

  // Read data selection; unmapped addresses read zero
  assign rd_mux = sel_status ? event_view :
                  sel_enable ? hdlc_irq_enable_q :
                  sel_info ? rx_info_view : 8'h00;

  // Mask register
  always_ff @(posedge clock) begin
    if (!resetn) begin
      hdlc_irq_enable_q <= IRQ_ENABLE_RESET;
    end else if (clk_en && wr_en && sel_enable) begin
      hdlc_irq_enable_q <= wr_data;
    end
  end

  // Status, sticky flags, read data and interrupt
  always_ff @(posedge clock) begin
    if (!resetn) begin
      status_q <= EVENT_STATUS_RESET;
      sticky_q <= RX_STICKY_RESET;
      rd_data <= 8'h00;
      irq_n <= 1'b1;
    end else if (clk_en) begin
      status_q <= status_d;
      sticky_q <= sticky_d;
      rd_data <= rd_en ? rd_mux : rd_data;
      irq_n <= ~|(event_view & hdlc_irq_enable_q);
    end
  end

  // Checks
  a_abort_sets: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && abort_pulse |=> sticky_q[3])
    else $error("abort flag not set");
  a_sticky_hold: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && sticky_q[2] && !rd_info |=> sticky_q[2])
    else $error("crc flag lost without read");
  a_read_clears: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && rd_info && !abort_pulse |=> !sticky_q[3])
    else $error("abort flag not cleared by read");
  a_overrun_full: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && fifo_push && fifo_level == LW'(FIFO_DEPTH) |=> sticky_q[1])
    else $error("overrun not flagged");
  a_valid_sets: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && packet_checked_ok |=> sticky_q[0])
    else $error("valid flag not set");
  a_crc_sets: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && crc_bad |=> sticky_q[2])
    else $error("crc flag not set");
  a_irq_masked: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && hdlc_irq_enable_q == 8'h00 && !$past(wr_en) |=> irq_n)
    else $error("interrupt with all masked");
  a_empty_read: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && rd_info && fifo_level == '0 |=> rd_data[BIT_EMPTY])
    else $error("empty bit wrong");
  a_good_needs_last: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && rd_info |=> !rd_data[BIT_GOOD_LAST] || rd_data[BIT_CLOSING])
    else $error("good mark without closing");
  a_status_clear: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && rd_status && !packet_start_event |=> !status_q[BIT_PKT_START])
    else $error("latched status not cleared");
  a_mask_write: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && wr_en && sel_enable |=> hdlc_irq_enable_q == $past(wr_data))
    else $error("mask write lost");
  a_half_full_read: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && rd_status && fifo_level > HALF_LEVEL |=> rd_data[BIT_RX_HALF])
    else $error("half full not shown");
  a_closing_read: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && rd_info && head_last && fifo_level != '0 |=> rd_data[BIT_CLOSING])
    else $error("closing mark missing");
  a_opening_read: assert property (@(posedge clock) disable iff (!resetn)
    clk_en && rd_info && head_first && fifo_level != '0 |=> rd_data[BIT_OPENING])
    else $error("opening mark missing");
  // A frozen cycle must not move the flags or the mask
  a_freeze_hold: assert property (@(posedge clock) disable iff (!resetn)
    !clk_en |=> $stable(sticky_q) && $stable(hdlc_irq_enable_q))
    else $error("state moved while frozen");
  c_abort: cover property (@(posedge clock) abort_pulse);
  c_irq: cover property (@(posedge clock) !irq_n);
  c_overrun: cover property (@(posedge clock) overrun_d);
  c_good_last: cover property (@(posedge clock) rx_info_view[BIT_GOOD_LAST]);
  c_half_full: cover property (@(posedge clock) rx_fifo_half_full);
endmodule

// ==== inc/hdlc_stat_pkg.sv ====
package hdlc_stat_pkg;
  // Register addresses on the parallel control port
  localparam logic [7:0] ADDR_EVENT_STATUS = 8'h01;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h02;
  localparam logic [7:0] ADDR_RX_INFO = 8'h03;
  // Reset values
  localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
  localparam logic [7:0] EVENT_STATUS_RESET = 8'h00;
  localparam logic [3:0] RX_STICKY_RESET = 4'h0;
  // Event bit positions, shared by mask and status registers
  localparam int BIT_CODE_CHANGE = 7;
  localparam int BIT_PKT_END = 6;
  localparam int BIT_PKT_START = 5;
  localparam int BIT_RX_HALF = 4;
  localparam int BIT_RX_HAS_DATA = 3;
  localparam int BIT_TX_HALF = 2;
  localparam int BIT_TX_ROOM = 1;
  localparam int BIT_TX_DONE = 0;
  // Receive information bit positions
  localparam int BIT_ABORT = 7;
  localparam int BIT_CRC_ERR = 6;
  localparam int BIT_OVERRUN = 5;
  localparam int BIT_VALID = 4;
  localparam int BIT_EMPTY = 3;
  localparam int BIT_GOOD_LAST = 2;
  localparam int BIT_CLOSING = 1;
  localparam int BIT_OPENING = 0;
  // Abort is seven or more ones in a row
  localparam int ABORT_ONES = 7;
  // Receive FIFO depth in bytes
  localparam int RX_FIFO_DEPTH = 64;
  // Latched event mask within the status register
  localparam logic [7:0] LATCHED_EVENTS = 8'he1;
endpackage

// ==== hdl/hdlc_ones_run.sv ====
`timescale 1ns/10ps
// Counts consecutive ones on the received bit stream
module hdlc_ones_run #(
  parameter int RUN = 7
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic enable,
  input wire logic bit_valid,
  input wire logic bit_value,
  output logic abort_pulse
);
  initial begin
    if (RUN < 2 || RUN > 255) $error("RUN out of range");
  end
  logic [7:0] run_q;
  logic [7:0] run_d;
  logic hit_d;
  // Saturate so a long idle of ones does not wrap and re-fire
  assign hit_d = bit_valid && bit_value && (run_q == 8'(RUN - 1));
  assign run_d = !bit_valid ? run_q : !bit_value ? 8'h00 :
                 (run_q == 8'hff) ? run_q : run_q + 8'h01;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      run_q <= 8'h00;
      abort_pulse <= 1'b0;
    end else if (enable) begin
      run_q <= run_d;
      abort_pulse <= hit_d;
    end
  end
endmodule

// ==== verif/ctrl_port_host.sv ====
`timescale 1ns/10ps
// Host on the control port; moves only after falling edges
module ctrl_port_host (
  input wire logic clock,
  output logic [7:0] addr,
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data
);
  initial begin
    addr = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    wr_data = 8'h00;
  end
  // Data inverted after the strobe so no stale value lingers
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    addr = a;
    wr_data = d;
    wr_en = 1'b1;
    @(negedge clock);
    wr_en = 1'b0;
    wr_data = ~d;
  endtask
  // Registered answer, so taken a cycle and a half after the rising edge that registers it
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    addr = a;
    rd_en = 1'b1;
    @(negedge clock);
    rd_en = 1'b0;
    @(negedge clock);
    d = rd_data;
  endtask
endmodule

// ==== verif/hdlc_rx_status_tb_top.sv ====
`timescale 1ns/10ps
// Scenario bench for the mask and receive information registers
module hdlc_rx_status_tb_top;
  import hdlc_stat_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr, wr_data, rd_data, got;
  logic wr_en, rd_en, irq_n, bv = 1'b0, bt = 1'b0, crc = 1'b0, ok = 1'b0, push = 1'b0;
  logic hf = 1'b0, hl = 1'b0, hg = 1'b0, pend = 1'b0, room = 1'b0;
  logic cdc = 1'b0, pst = 1'b0, tmd = 1'b0, thf = 1'b0, en = 1'b1;
  logic [6:0] lvl = 7'h00;
  int bad_count = 0;
  int compares = 0;
  always #12.5 clock = ~clock;
  ctrl_port_host u_ctrl_port_host (.clock(clock), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
    .wr_data(wr_data), .rd_data(rd_data));
  // Every event input is driven so each mask bit can be reached
  hdlc_rx_status u_hdlc_rx_status (.clock(clock), .resetn(resetn), .clk_en(en),
    .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .wr_data(wr_data), .rd_data(rd_data),
    .rx_bit_valid(bv), .rx_bit(bt), .crc_bad(crc), .packet_checked_ok(ok),
    .fifo_push(push), .fifo_level(lvl), .head_first(hf), .head_last(hl), .head_good(hg),
    .code_detector_change(cdc), .packet_start_event(pst), .packet_end_event(pend),
    .tx_fifo_half_empty(thf), .tx_fifo_has_room(room), .tx_message_done(tmd),
    .irq_n(irq_n));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    u_ctrl_port_host.read_reg(a, got);
    chk(n, e, got);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Gaps in bit valid are left in on purpose; they must not break a run
  task automatic bits(input int n, input logic b);
    repeat (n) begin
      @(negedge clock);
      bv = 1'b1;
      bt = b;
    end
    @(negedge clock);
    bv = 1'b0;
  endtask
  task automatic t_mask();
    chk("irq_n reset", 8'h01, {7'h00, irq_n});
    rd(ADDR_IRQ_ENABLE, IRQ_ENABLE_RESET, "mask reset");
    rd(8'h07, 8'h00, "unmapped");
    room = 1'b1;
    u_ctrl_port_host.write_reg(ADDR_IRQ_ENABLE, 8'h02);
    idle(2);
    chk("irq_n room", 8'h00, {7'h00, irq_n});
    rd(ADDR_IRQ_ENABLE, 8'h02, "mask back");
    u_ctrl_port_host.write_reg(ADDR_IRQ_ENABLE, 8'h40);
    idle(2);
    chk("irq_n masked", 8'h01, {7'h00, irq_n});
    pend = 1'b1;
    idle(1);
    pend = 1'b0;
    idle(3);
    chk("irq_n end", 8'h00, {7'h00, irq_n});
    rd(ADDR_EVENT_STATUS, 8'h42, "status");
    chk("irq_n cleared", 8'h01, {7'h00, irq_n});
    room = 1'b0;
    $display("test mask done");
  endtask
  task automatic t_abort();
    rd(ADDR_RX_INFO, 8'h08, "info reset");
    bits(6, 1'b1);
    bits(1, 1'b0);
    idle(3);
    rd(ADDR_RX_INFO, 8'h08, "six ones");
    bits(7, 1'b1);
    idle(3);
    rd(ADDR_RX_INFO, 8'h88, "abort");
    rd(ADDR_RX_INFO, 8'h08, "abort cleared");
    bits(1, 1'b0);
    bits(4, 1'b1);
    bits(3, 1'b1);
    idle(3);
    rd(ADDR_RX_INFO, 8'h88, "abort across gap");
    $display("test abort done");
  endtask
  task automatic t_flags();
    lvl = 7'h40;
    @(negedge clock);
    {crc, ok, push} = 3'b111;
    @(negedge clock);
    {crc, ok, push} = 3'b000;
    rd(ADDR_RX_INFO, 8'h70, "flags");
    {lvl, hf, hl, hg} = {7'h05, 3'b111};
    rd(ADDR_RX_INFO, 8'h07, "good last");
    hg = 1'b0;
    rd(ADDR_RX_INFO, 8'h03, "bad last");
    hl = 1'b0;
    rd(ADDR_RX_INFO, 8'h01, "first");
    $display("test flags done");
  endtask
  // Latched pulses beside live levels, then single mask bits, then three frozen cycles
  task automatic t_events();
    {lvl, hf} = {7'h21, 1'b0};
    thf = 1'b1;
    @(negedge clock);
    {cdc, pst, tmd} = 3'b111;
    @(negedge clock);
    {cdc, pst, tmd} = 3'b000;
    rd(ADDR_EVENT_STATUS, 8'hbd, "latched and live");
    rd(ADDR_EVENT_STATUS, 8'h1c, "latched cleared");
    lvl = 7'h20;
    rd(ADDR_EVENT_STATUS, 8'h0c, "at midpoint");
    u_ctrl_port_host.write_reg(ADDR_IRQ_ENABLE, 8'h08);
    idle(2);
    chk("irq_n has data", 8'h00, {7'h00, irq_n});
    u_ctrl_port_host.write_reg(ADDR_IRQ_ENABLE, 8'h04);
    idle(2);
    chk("irq_n tx half", 8'h00, {7'h00, irq_n});
    u_ctrl_port_host.write_reg(ADDR_IRQ_ENABLE, 8'hb1);
    idle(2);
    chk("irq_n quiet", 8'h01, {7'h00, irq_n});
    @(negedge clock);
    tmd = 1'b1;
    @(negedge clock);
    tmd = 1'b0;
    idle(2);
    chk("irq_n tx done", 8'h00, {7'h00, irq_n});
    rd(ADDR_EVENT_STATUS, 8'h0d, "tx done");
    chk("irq_n done cleared", 8'h01, {7'h00, irq_n});
    en = 1'b0;
    u_ctrl_port_host.write_reg(ADDR_IRQ_ENABLE, 8'h00);
    ok = 1'b1;
    idle(1);
    {ok, en} = 2'b01;
    rd(ADDR_IRQ_ENABLE, 8'hb1, "mask frozen");
    rd(ADDR_RX_INFO, 8'h00, "valid frozen");
    thf = 1'b0;
    $display("test events done");
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #(25 * 600);
    bad_count++;
    close_out();
  end
  initial begin
    idle(4);
    resetn = 1'b1;
    t_mask();
    t_abort();
    t_flags();
    t_events();
    close_out();
  end
endmodule
